// *** e1oh_defs.vh ***
// Constants for the E1 TS16/TS0 overhead controller.
// Assumes inclusion by e1oh_ctrl.v only; definitions only.
`ifndef E1OH_DEFS_VH
`define E1OH_DEFS_VH

// Register offsets on the plain register port
`define E1OH_A_RAC      4'h0
`define E1OH_A_SIE      4'h1
`define E1OH_A_SASRC    4'h2
`define E1OH_A_SAMSK    4'h3
`define E1OH_A_DLSEL    4'h4
`define E1OH_A_TS16C    4'h5
`define E1OH_A_SIGC     4'h6
`define E1OH_A_STAT1    4'h7

// Reset values of the writable registers
`define E1OH_RST_REG    8'h00

// Field positions
`define E1OH_SIE_SEL    0
`define E1OH_SIE_FAS_SI_CTRL_BIT   1
`define E1OH_SIE_NOTFAS_SI_CTRL_BIT  2
`define E1OH_SIE_AUTO   3
`define E1OH_SIE_LOSS   4
`define E1OH_SIE_TMR    5
`define E1OH_RAC_MAN    7
`define E1OH_DL_EXT     6
`define E1OH_TS16C_RMA  4
`define E1OH_SIGC_AIS   6
`define E1OH_ST_SIGLOST 1
`define E1OH_ST_BFLOST  4
`define E1OH_ST_BFFOUND 5

// Sa source upper field codes and the all-ones Sa value
`define E1OH_SRC_REG    3'b000
`define E1OH_SRC_SYS    3'b001
`define E1OH_SA_ALL     5'h1f

// Multiframe figures
`define E1OH_MF_LAST    4'hf
`define E1OH_ZERO_LIM   6'h20
`define E1OH_ERR_LIM    2'h2
`define E1OH_E_FRM_A    4'hd
`define E1OH_E_FRM_B    4'hf

`endif

// *** e1oh_ctrl.v ***
// E1 time slot 16 multiframe alignment and time slot 0 overhead sourcing.
// Assumes per-frame strobes from the line framer, all on clk_sys, and a
// system highway that keeps the biframe marker when it sources overhead.
// What this block does
// - Basic frame loss also puts receiver into signaling multiframe lost.
// - Two consecutive errored 0000 multiframe patterns mean signaling MF lost.
// - Time slot 16 all zero for two whole multiframes means signaling MF lost.
// - Signaling multiframe lost shows in bit 1 of framer status one.
// - Search only when frame aligned; align on 0000 after a TS16 with a one.
// - While lost: freeze signaling, spare bits forced 1, remote alarm forced 0.
// - While lost and TS16 control bit 4 set, send remote multiframe alarm.
// - While lost and signaling control bit 6 set, AIS replaces system TS16.
// - Non-CRC-4 with select 1: FAS Si and NOT FAS Si bits sent in bit 1.
// - Missing biframe marker flags status bit 4, searches, signals regain.
// - CRC-4 with select 0: FAS Si as E in frame 13, NOT FAS in 15.
// - CRC-4 with select 1: each written 0 sends one E bit 0 there.
// - Enable bit 3: one E bit 0 per errored received CRC-4 submultiframe, at most 3 held pending.
// - E bits 0 in CRC-4 MF loss (bit 4) or after timer (bit 5).
// - A bit 0 normally, 1 while manual alarm bit 7 is set.
// - A bit 1 during each enabled loss or received Sa6 code condition.
// - Sa bits from Sa source low bits when upper 000 and mask 11111.
// - Upper bit 7: Sa from external link if bit 6, else internal HDLC.
// - Upper 01x takes Sa from transmit stack, 001 from system highway.
// - Frame loss in CRC-4 forces CRC-4 MF loss; E monitoring pauses.
// - Remote multiframe alarm is frame 0 TS16 bit, 1 meaning alarm.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "e1oh_defs.vh"

module e1oh_ctrl (
	input  wire       clk_sys,
	input  wire       rst_n,
	// Register port
	input  wire [3:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata_q,
	// Receive framer conditions
	input  wire       basic_frame_lost,
	input  wire       crc4_mode,
	input  wire       crc4_mf_lost_in,
	input  wire       crc4_timer_expired,
	input  wire       crc4_smf_error,
	input  wire       sa6_code_eight,
	input  wire       sa6_code_twelve,
	input  wire       rx_ts16_valid,
	input  wire [7:0] rx_ts16_byte,
	// System highway TS0 byte, one per frame
	input  wire       sys_ts0_valid,
	input  wire [7:0] sys_ts0_byte,
	// Other Sa sources
	input  wire       ext_datalink_input,
	input  wire       internal_datalink_bit,
	input  wire [4:0] tx_stack_sa,
	// Transmit frame strobe from the transmit framer
	input  wire       tx_frame_valid,
	input  wire       tx_frame_fas,
	input  wire [3:0] tx_frame_num,
	// Receive side results
	output reg        signaling_multiframe_lost_q,
	output reg        crc4_multiframe_lost_q,
	output reg        rx_ebit_monitor_en_q,
	output reg        rx_sig_update_en_q,
	output reg  [2:0] rx_spare_bits_q,
	output reg        rx_rma_status_q,
	output reg        sys_ts16_ais_q,
	// Transmit overhead bits
	output reg        tx_ts16_rma_q,
	output reg        tx_si_bit_q,
	output reg        tx_a_bit_q,
	output reg  [4:0] tx_sa_bits_q
);
////////////////////////////////////////////////////////////////////////
// Register file
reg  [7:0] rac_q;
reg  [7:0] sie_q;
reg  [7:0] sasrc_q;
reg  [7:0] samsk_q;
reg  [7:0] dlsel_q;
reg  [7:0] ts16c_q;
reg  [7:0] sigc_q;
reg        bf_found_q;
reg        bf_lost_q;
wire wr_sie   = reg_wr & (reg_addr == `E1OH_A_SIE);
wire wr_sasrc = reg_wr & (reg_addr == `E1OH_A_SASRC);
wire rd_stat  = reg_rd & (reg_addr == `E1OH_A_STAT1);
// Writes of the control registers
always @(posedge clk_sys) begin
	if (!rst_n) begin
		rac_q   <= `E1OH_RST_REG;
		sie_q   <= `E1OH_RST_REG;
		sasrc_q <= `E1OH_RST_REG;
		samsk_q <= `E1OH_RST_REG;
		dlsel_q <= `E1OH_RST_REG;
		ts16c_q <= `E1OH_RST_REG;
		sigc_q  <= `E1OH_RST_REG;
	end else if (reg_wr) begin
		case (reg_addr)
		`E1OH_A_RAC:   rac_q   <= reg_wdata;
		`E1OH_A_SIE:   sie_q   <= reg_wdata;
		`E1OH_A_SASRC: sasrc_q <= reg_wdata;
		`E1OH_A_SAMSK: samsk_q <= reg_wdata;
		`E1OH_A_DLSEL: dlsel_q <= reg_wdata;
		`E1OH_A_TS16C: ts16c_q <= reg_wdata;
		`E1OH_A_SIGC:  sigc_q  <= reg_wdata;
		default: ;
		endcase
	end
end

// Status image; regain flag is sticky until read
wire [7:0] stat1 = {2'b00, bf_found_q, bf_lost_q, 2'b00,
	signaling_multiframe_lost_q, 1'b0};

// Read data one cycle after the strobe, zero for unmapped offsets
always @(posedge clk_sys) begin
	if (!rst_n || !reg_rd) begin
		reg_rdata_q <= 8'h00;
	end else begin
		case (reg_addr)
		`E1OH_A_RAC:   reg_rdata_q <= rac_q;
		`E1OH_A_SIE:   reg_rdata_q <= sie_q;
		`E1OH_A_SASRC: reg_rdata_q <= sasrc_q;
		`E1OH_A_SAMSK: reg_rdata_q <= samsk_q;
		`E1OH_A_DLSEL: reg_rdata_q <= dlsel_q;
		`E1OH_A_TS16C: reg_rdata_q <= ts16c_q;
		`E1OH_A_SIGC:  reg_rdata_q <= sigc_q;
		`E1OH_A_STAT1: reg_rdata_q <= stat1;
		default:       reg_rdata_q <= 8'h00;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// Time slot 16 multiframe alignment
reg  [3:0] mf_pos_q;
reg  [1:0] pat_err_q;
reg  [5:0] zero_run_q;
reg        prev_one_q;
wire       ts16_zero = (rx_ts16_byte == 8'h00);
wire       pat_ok    = (rx_ts16_byte[7:4] == 4'h0);
wire [1:0] err_nx    = pat_err_q + 2'h1;
wire [5:0] zrun_nx   = zero_run_q + 6'h01;
// Search, lock and loss per received TS16 octet
always @(posedge clk_sys) begin
	if (!rst_n) begin
		signaling_multiframe_lost_q <= 1'b1;
		mf_pos_q   <= 4'h0;
		pat_err_q  <= 2'h0;
		zero_run_q <= 6'h00;
		prev_one_q <= 1'b0;
	end else if (basic_frame_lost) begin
		signaling_multiframe_lost_q <= 1'b1;
		prev_one_q <= 1'b0;
		pat_err_q  <= 2'h0;
		zero_run_q <= 6'h00;
	end else if (rx_ts16_valid) begin
		prev_one_q <= ~ts16_zero;
		if (signaling_multiframe_lost_q) begin
			// Alignment needs a one in the octet just before
			if (pat_ok && prev_one_q) begin
				signaling_multiframe_lost_q <= 1'b0;
				mf_pos_q <= 4'h1;
			end
			pat_err_q  <= 2'h0;
			zero_run_q <= 6'h00;
		end else begin
			mf_pos_q <= mf_pos_q + 4'h1;
			zero_run_q <= ts16_zero ? zrun_nx : 6'h00;
			if (ts16_zero && zrun_nx == `E1OH_ZERO_LIM) begin
				signaling_multiframe_lost_q <= 1'b1;
			end
			if (mf_pos_q == 4'h0) begin
				pat_err_q <= pat_ok ? 2'h0 : err_nx;
				if (!pat_ok && err_nx == `E1OH_ERR_LIM) begin
					signaling_multiframe_lost_q <= 1'b1;
				end
			end
		end
	end
end

// Receive consequent actions; spare and alarm bits live in frame 0
always @(posedge clk_sys) begin
	if (!rst_n) begin
		rx_spare_bits_q    <= 3'h7;
		rx_rma_status_q    <= 1'b0;
		rx_sig_update_en_q <= 1'b0;
		tx_ts16_rma_q      <= 1'b0;
		sys_ts16_ais_q     <= 1'b0;
	end else begin
		rx_sig_update_en_q <= ~signaling_multiframe_lost_q;
		tx_ts16_rma_q <= signaling_multiframe_lost_q &
			ts16c_q[`E1OH_TS16C_RMA];
		sys_ts16_ais_q <= signaling_multiframe_lost_q &
			sigc_q[`E1OH_SIGC_AIS];
		if (signaling_multiframe_lost_q) begin
			rx_spare_bits_q <= 3'h7;
			rx_rma_status_q <= 1'b0;
		end else if (rx_ts16_valid && mf_pos_q == 4'h0) begin
			rx_spare_bits_q <= {rx_ts16_byte[0], rx_ts16_byte[1],
				rx_ts16_byte[3]};
			rx_rma_status_q <= rx_ts16_byte[2];
		end
	end
end

////////////////////////////////////////////////////////////////////////
// CRC-4 loss forcing and A bit
// Frame loss in CRC-4 mode implies multiframe loss
wire crc_lost = crc4_mf_lost_in | (crc4_mode & basic_frame_lost);
// A bit and E-bit monitor gate follow the conditions level by level
always @(posedge clk_sys) begin
	if (!rst_n) begin
		crc4_multiframe_lost_q <= 1'b0;
		rx_ebit_monitor_en_q   <= 1'b0;
		tx_a_bit_q             <= 1'b0;
	end else begin
		crc4_multiframe_lost_q <= crc_lost;
		rx_ebit_monitor_en_q <= crc4_mode & ~crc_lost;
		tx_a_bit_q <= rac_q[`E1OH_RAC_MAN] |
			(rac_q[0] & basic_frame_lost) |
			(rac_q[1] & signaling_multiframe_lost_q) |
			(rac_q[2] & crc_lost) |
			(rac_q[3] & crc_lost & crc4_timer_expired) |
			(rac_q[4] & sa6_code_eight) |
			(rac_q[5] & sa6_code_twelve);
	end
end

////////////////////////////////////////////////////////////////////////
// System biframe alignment and captured system overhead
reg  bf_expect_q;
reg  bf_seen1_q;
reg  sys_si_fas_q;
reg  sys_si_nf_q;
reg  [4:0] sys_sa_q;
wire sys_mark = sys_ts0_byte[6]; // Bit 2 of TS0, just after Si
wire restart  = wr_sasrc & (reg_wdata[7:5] == `E1OH_SRC_SYS);
wire bf_regain = sys_ts0_valid & bf_lost_q & bf_seen1_q & ~sys_mark & ~restart;
// Marker must alternate 1 then 0; a break restarts the search
always @(posedge clk_sys) begin
	if (!rst_n) begin
		bf_lost_q   <= 1'b1;
		bf_seen1_q  <= 1'b0;
		bf_expect_q <= 1'b1;
	end else if (restart) begin
		bf_lost_q   <= 1'b1;
		bf_seen1_q  <= 1'b0;
		bf_expect_q <= 1'b1;
	end else if (sys_ts0_valid) begin
		if (bf_lost_q) begin
			bf_seen1_q <= sys_mark;
			if (bf_regain) begin
				bf_lost_q   <= 1'b0;
				bf_expect_q <= 1'b1;
			end
		end else if (sys_mark != bf_expect_q) begin
			bf_lost_q  <= 1'b1;
			bf_seen1_q <= sys_mark;
		end else begin
			bf_expect_q <= ~bf_expect_q;
		end
	end
end

// Regain flag: set beats the clearing read
always @(posedge clk_sys) begin
	if (!rst_n) begin
		bf_found_q <= 1'b0;
	end else if (bf_regain) begin
		bf_found_q <= 1'b1;
	end else if (rd_stat) begin
		bf_found_q <= 1'b0;
	end
end

// Capture system Si and Sa; held while searching, so line data may stale
always @(posedge clk_sys) begin
	if (!rst_n) begin
		sys_si_fas_q <= 1'b1;
		sys_si_nf_q  <= 1'b1;
		sys_sa_q     <= `E1OH_SA_ALL;
	end else if (sys_ts0_valid && !bf_lost_q) begin
		if (sys_mark) begin
			sys_si_nf_q <= sys_ts0_byte[7];
			sys_sa_q    <= sys_ts0_byte[4:0];
		end else begin
			sys_si_fas_q <= sys_ts0_byte[7];
		end
	end
end

////////////////////////////////////////////////////////////////////////
// E-bit requests
reg        man_a_q;
reg        man_b_q;
reg  [1:0] err_pend_q;
wire sel_one   = sie_q[`E1OH_SIE_SEL];
wire e_slot_a  = tx_frame_valid & (tx_frame_num == `E1OH_E_FRM_A);
wire e_slot_b  = tx_frame_valid & (tx_frame_num == `E1OH_E_FRM_B);
wire e_slot    = crc4_mode & (e_slot_a | e_slot_b);
wire set_a     = crc4_mode & wr_sie & reg_wdata[`E1OH_SIE_SEL] &
	~reg_wdata[`E1OH_SIE_FAS_SI_CTRL_BIT];
wire set_b     = crc4_mode & wr_sie & reg_wdata[`E1OH_SIE_SEL] &
	~reg_wdata[`E1OH_SIE_NOTFAS_SI_CTRL_BIT];
wire err_in    = crc4_smf_error & sie_q[`E1OH_SIE_AUTO];
wire err_use   = e_slot & (err_pend_q != 2'h0);
wire e_forced  = crc_lost & (sie_q[`E1OH_SIE_LOSS] |
	(sie_q[`E1OH_SIE_TMR] & crc4_timer_expired));
// One-shot manual and error requests; a new request beats consumption
always @(posedge clk_sys) begin
	if (!rst_n) begin
		man_a_q    <= 1'b0;
		man_b_q    <= 1'b0;
		err_pend_q <= 2'h0;
	end else begin
		if (set_a) begin
			man_a_q <= 1'b1;
		end else if (crc4_mode && e_slot_a) begin
			man_a_q <= 1'b0;
		end
		if (set_b) begin
			man_b_q <= 1'b1;
		end else if (crc4_mode && e_slot_b) begin
			man_b_q <= 1'b0;
		end
		if (err_in && !err_use && err_pend_q != 2'h3) begin
			err_pend_q <= err_pend_q + 2'h1;
		end else if (!err_in && err_use) begin
			err_pend_q <= err_pend_q - 2'h1;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Transmit Si and Sa bits
reg        e_bit;
reg        si_next;
wire [4:0] sa_next;
wire       dl_bit = dlsel_q[`E1OH_DL_EXT] ? ext_datalink_input :
	internal_datalink_bit;
// Per-position Sa source choice
genvar gi;
generate
	for (gi = 0; gi < 5; gi = gi + 1) begin : g_sa
		assign sa_next[gi] =
			sasrc_q[7] ? (samsk_q[gi] ? dl_bit : 1'b1) :
			sasrc_q[6] ? tx_stack_sa[gi] :
			sasrc_q[5] ? sys_sa_q[gi] :
			(samsk_q[gi] ? sasrc_q[gi] : 1'b1);
	end
endgenerate

// Si or E bit for the current frame
always @* begin
	e_bit = 1'b1;
	if (!sel_one) begin
		e_bit = e_slot_a ? sie_q[`E1OH_SIE_FAS_SI_CTRL_BIT] :
			sie_q[`E1OH_SIE_NOTFAS_SI_CTRL_BIT];
	end else if ((e_slot_a && man_a_q) || (e_slot_b && man_b_q)) begin
		e_bit = 1'b0;
	end
	if (err_use || e_forced) begin
		e_bit = 1'b0;
	end
	if (crc4_mode) begin
		si_next = e_slot ? e_bit : 1'b1;
	end else if (sel_one) begin
		si_next = tx_frame_fas ? sie_q[`E1OH_SIE_FAS_SI_CTRL_BIT] :
			sie_q[`E1OH_SIE_NOTFAS_SI_CTRL_BIT];
	end else begin
		si_next = tx_frame_fas ? sys_si_fas_q : sys_si_nf_q;
	end
end

// Si updates once per transmitted frame, Sa bits only on NOT FAS frames
always @(posedge clk_sys) begin
	if (!rst_n) begin
		tx_si_bit_q  <= 1'b1;
		tx_sa_bits_q <= `E1OH_SA_ALL;
	end else if (tx_frame_valid) begin
		tx_si_bit_q <= si_next;
		if (!tx_frame_fas) begin
			tx_sa_bits_q <= sa_next;
		end
	end
end
endmodule // e1oh_ctrl

// *** e1oh_ctrl_assertions.sv ***
// Checker: port-level relations of the overhead controller.
// Assumes a bind to e1oh_ctrl and a single clock domain.
`timescale 1ns/1ns
module e1oh_chk (
	input wire       clk_sys,
	input wire       rst_n,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata_q,
	input wire       basic_frame_lost,
	input wire       crc4_mode,
	input wire       rx_ts16_valid,
	input wire [7:0] rx_ts16_byte,
	input wire       signaling_multiframe_lost_q,
	input wire       crc4_multiframe_lost_q,
	input wire       rx_ebit_monitor_en_q,
	input wire       rx_sig_update_en_q,
	input wire [2:0] rx_spare_bits_q,
	input wire       rx_rma_status_q,
	input wire       sys_ts16_ais_q,
	input wire       tx_ts16_rma_q,
	input wire       tx_a_bit_q
);
////////////////////////////////////////
reg [7:0] rac_q, t16_q, sig_q;
// Mirror of the enables, since only the ports are visible here
always @(posedge clk_sys) begin
	if (!rst_n) begin
		rac_q <= 8'h00;
		t16_q <= 8'h00;
		sig_q <= 8'h00;
	end else if (reg_wr) begin
		if (reg_addr == 4'h0) rac_q <= reg_wdata;
		if (reg_addr == 4'h5) t16_q <= reg_wdata;
		if (reg_addr == 4'h6) sig_q <= reg_wdata;
	end
end
////////////////////////////////////////
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
// Lock steps: an octet holding a one, then a 0000 header
sequence one_oct;
	rx_ts16_valid && rx_ts16_byte != 8'h00 && !basic_frame_lost;
endsequence
sequence hdr_oct;
	rx_ts16_valid && rx_ts16_byte[7:4] == 4'h0 && !basic_frame_lost;
endsequence
lost_on_bfl_a: assert property (
	basic_frame_lost |=> signaling_multiframe_lost_q)
	else $error("no ts16 loss on frame loss");
sig_lock_a: assert property (
	one_oct ##1 hdr_oct |=> !signaling_multiframe_lost_q)
	else $error("no ts16 lock on header");
lost_force_a: assert property (
	signaling_multiframe_lost_q |=> rx_spare_bits_q == 3'b111
	&& !rx_rma_status_q && !rx_sig_update_en_q)
	else $error("received ts16 bits not forced");
stat_bit_a: assert property (
	reg_rd && reg_addr == 4'h7 |=>
	reg_rdata_q[1] == $past(signaling_multiframe_lost_q))
	else $error("status bit 1 wrong");
rma_send_a: assert property (
	(signaling_multiframe_lost_q && t16_q[4]) [*3] |-> tx_ts16_rma_q)
	else $error("remote multiframe alarm missing");
ais_sys_a: assert property (
	(signaling_multiframe_lost_q && sig_q[6]) [*3] |-> sys_ts16_ais_q)
	else $error("system ts16 ais missing");
a_man_a: assert property (
	rac_q[7] [*3] |-> tx_a_bit_q)
	else $error("manual a bit ignored");
a_idle_a: assert property (
	(rac_q == 8'h00) [*3] |-> !tx_a_bit_q)
	else $error("a bit set with no enable");
crc_force_a: assert property (
	(crc4_mode && basic_frame_lost) [*3] |->
	crc4_multiframe_lost_q && !rx_ebit_monitor_en_q)
	else $error("crc4 loss not forced");
endmodule // e1oh_chk

bind e1oh_ctrl e1oh_chk u_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_q(reg_rdata_q), .basic_frame_lost(basic_frame_lost),
	.crc4_mode(crc4_mode), .rx_ts16_valid(rx_ts16_valid),
	.rx_ts16_byte(rx_ts16_byte),
	.signaling_multiframe_lost_q(signaling_multiframe_lost_q),
	.crc4_multiframe_lost_q(crc4_multiframe_lost_q),
	.rx_ebit_monitor_en_q(rx_ebit_monitor_en_q),
	.rx_sig_update_en_q(rx_sig_update_en_q),
	.rx_spare_bits_q(rx_spare_bits_q), .rx_rma_status_q(rx_rma_status_q),
	.sys_ts16_ais_q(sys_ts16_ais_q), .tx_ts16_rma_q(tx_ts16_rma_q),
	.tx_a_bit_q(tx_a_bit_q)
);

// *** e1oh_sys_hwy.sv ***
// System highway model: one time slot 0 octet per send pulse.
// Assumes the bench paces send; marker is TS0 bit 2, bit 3 is 0 in both octets.
`timescale 1ns/1ns
module e1oh_sys_hwy (
	input  wire       clk_sys,
	input  wire       rst_n,
	input  wire       send,
	input  wire       bad_mark,
	input  wire [4:0] sa_val,
	output reg        sys_ts0_valid,
	output reg  [7:0] sys_ts0_byte
);
reg mark_q;
// Marker alternates 1,0; bad_mark sticks it at 1 to break alignment
always @(posedge clk_sys) begin
	if (!rst_n) begin
		mark_q <= 1'b1;
		sys_ts0_valid <= 1'b0;
		sys_ts0_byte <= 8'h00;
	end else if (send) begin
		sys_ts0_valid <= 1'b1;
		// NOT FAS octet has bit 2 high; FAS octet is Si then 0011011
		sys_ts0_byte <= mark_q ? {2'b11, 1'b0, sa_val} : 8'h9b;
		mark_q <= bad_mark | ~mark_q;
	end else begin
		sys_ts0_valid <= 1'b0;
		sys_ts0_byte <= ~sys_ts0_byte; // Inverted between frames; the stale octet returns every second idle cycle
	end
end
endmodule // e1oh_sys_hwy

// *** tb_top.sv ***
// Self-checking bench for the overhead controller.
// Assumes the controller, its checker and the highway model.
`timescale 1ns/1ns
module tb_top;
logic       clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
logic [3:0] reg_addr = 4'h0, tx_frame_num = 4'h0;
logic [7:0] reg_wdata = 8'h00, rx_ts16_byte = 8'h00;
logic       basic_frame_lost = 1'b0, crc4_mode = 1'b0, mfl = 1'b0;
logic       tmr = 1'b0, smf_err = 1'b0, e8 = 1'b0, e12 = 1'b0;
logic       rx_ts16_valid = 1'b0, ext_dl = 1'b0, int_dl = 1'b0;
logic [4:0] stack_sa = 5'h00, sa_val = 5'h00, sa;
logic       tx_frame_valid = 1'b0, tx_frame_fas = 1'b0;
logic       send = 1'b0, bad_mark = 1'b0, sys_v, lost, crc_l, mon;
logic       upd, rma, ais, t_rma, si, a_bit;
logic [7:0] sys_b, rdata, d;
logic [2:0] spare;
int         error_cnt = 0, tests_run = 0, i, seed;

e1oh_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_q(rdata), .basic_frame_lost(basic_frame_lost),
	.crc4_mode(crc4_mode), .crc4_mf_lost_in(mfl),
	.crc4_timer_expired(tmr), .crc4_smf_error(smf_err),
	.sa6_code_eight(e8), .sa6_code_twelve(e12),
	.rx_ts16_valid(rx_ts16_valid), .rx_ts16_byte(rx_ts16_byte),
	.sys_ts0_valid(sys_v), .sys_ts0_byte(sys_b),
	.ext_datalink_input(ext_dl), .internal_datalink_bit(int_dl),
	.tx_stack_sa(stack_sa), .tx_frame_valid(tx_frame_valid),
	.tx_frame_fas(tx_frame_fas), .tx_frame_num(tx_frame_num),
	.signaling_multiframe_lost_q(lost), .crc4_multiframe_lost_q(crc_l),
	.rx_ebit_monitor_en_q(mon), .rx_sig_update_en_q(upd),
	.rx_spare_bits_q(spare), .rx_rma_status_q(rma),
	.sys_ts16_ais_q(ais), .tx_ts16_rma_q(t_rma), .tx_si_bit_q(si),
	.tx_a_bit_q(a_bit), .tx_sa_bits_q(sa));
e1oh_sys_hwy u_hwy (.clk_sys(clk_sys), .rst_n(rst_n), .send(send),
	.bad_mark(bad_mark), .sa_val(sa_val), .sys_ts0_valid(sys_v),
	.sys_ts0_byte(sys_b));
////////////////////////////////////////
// 250 MHz system clock
always #2 clk_sys = ~clk_sys;

function automatic [7:0] exp_rd(input [3:0] a, input [7:0] w);
	exp_rd = (a < 4'h7) ? w : ((a == 4'h7) ? 8'h12 : 8'h00);
endfunction
function automatic logic e_exp(input [7:0] r, input m, input t);
	e_exp = !((r[4] & m) | (r[5] & m & t));
endfunction
task chk(input string n, input [7:0] e, input [7:0] g);
	tests_run++;
	if (g !== e) begin
		error_cnt++;
		$display("[FAIL] %s exp %h got %h", n, e, g);
	end
endtask
task wr(input [3:0] a, input [7:0] v);
	@(posedge clk_sys);
	reg_wr <= 1'b1;
	reg_addr <= a;
	reg_wdata <= v;
	@(posedge clk_sys);
	reg_wr <= 1'b0;
endtask
task rdc(input [3:0] a, input [7:0] e);
	@(posedge clk_sys);
	reg_rd <= 1'b1;
	reg_addr <= a;
	@(posedge clk_sys);
	reg_rd <= 1'b0;
	#1 chk("rdata", e, rdata);
endtask
task ts(input [7:0] b);
	@(posedge clk_sys);
	rx_ts16_valid <= 1'b1;
	rx_ts16_byte <= b;
endtask
task idle(input int n);
	@(posedge clk_sys);
	rx_ts16_valid <= 1'b0;
	repeat (n) @(posedge clk_sys);
	#1;
endtask
task tx(input f, input [3:0] n);
	@(posedge clk_sys);
	tx_frame_valid <= 1'b1;
	tx_frame_fas <= f;
	tx_frame_num <= n;
	@(posedge clk_sys);
	tx_frame_valid <= 1'b0;
	#1;
endtask
task sys(input int n);
	repeat (n) begin
		@(posedge clk_sys);
		send <= 1'b1;
		@(posedge clk_sys);
		send <= 1'b0;
	end
endtask
task cond(input [5:0] c);
	@(posedge clk_sys);
	basic_frame_lost <= c[0] | c[1];
	mfl <= c[2] | c[3];
	tmr <= c[3];
	e8 <= c[4];
	e12 <= c[5];
	idle(3);
endtask
task summarize;
	$display("checks %0d errors %0d", tests_run, error_cnt);
	if (error_cnt == 0 && tests_run > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
////////////////////////////////////////
// Hang guard
initial begin
	repeat (20000) @(posedge clk_sys);
	error_cnt++;
	summarize;
end
initial begin
	seed = $urandom(32'he660);
	repeat (3) @(posedge clk_sys);
	rst_n <= 1'b1;
	// Reset values, random write-back, status and unmapped offsets
	for (i = 0; i < 16; i++) rdc(i[3:0], exp_rd(i[3:0], 8'h00));
	for (i = 0; i < 16; i++) begin
		d = (i == 1) ? 8'($urandom) | 8'h06 : 8'($urandom);
		wr(i[3:0], d);
		rdc(i[3:0], exp_rd(i[3:0], d));
	end
	for (i = 0; i < 7; i++) wr(i[3:0], 8'h00);
	// Octets are ignored while frame alignment is lost
	basic_frame_lost <= 1'b1;
	ts(8'h01);
	ts(8'h0f);
	idle(2);
	rdc(4'h7, 8'h12);
	basic_frame_lost <= 1'b0;
	ts(8'h01);
	ts(8'h07);
	idle(2);
	chk("lock", 8'h17, {lost, upd, rma, spare});
	rdc(4'h7, 8'h10);
	// One errored header is tolerated, a second in a row is not
	for (i = 0; i < 32; i++) begin
		ts((i % 16 == 15) ? 8'h87 : 8'h10 | 8'($urandom));
		if (i == 15) begin
			idle(2);
			chk("one_err", 8'h00, {7'h0, lost});
			chk("rx_rma", 8'h0e, {4'h0, rma, spare});
		end
	end
	idle(2);
	chk("two_err", 8'h27, {lost, rma, upd, spare});
	wr(4'h5, 8'h10);
	wr(4'h6, 8'h40);
	idle(3);
	chk("rma_ais", 8'h03, {6'h0, t_rma, ais});
	// All-zero time slot 16 for two multiframes, boundary at 32
	ts(8'h01);
	ts(8'h07);
	for (i = 1; i <= 32; i++) begin
		ts(8'h00);
		if (i == 31) idle(2);
		if (i == 31) chk("z31", 8'h00, {lost, t_rma, ais});
	end
	idle(2);
	chk("z32", 8'h01, {7'h0, lost});
	ts(8'h01);
	ts(8'h07);
	idle(2);
	basic_frame_lost <= 1'b1;
	idle(1);
	basic_frame_lost <= 1'b0;
	chk("bfl", 8'h01, {7'h0, lost});
	// Si control bits, non-CRC-4, every combination
	for (i = 0; i < 4; i++) begin
		wr(4'h1, {5'h0, i[1:0], 1'b1});
		tx(1'b1, 4'h0);
		chk("si_fas", {7'h0, i[0]}, {7'h0, si});
		tx(1'b0, 4'h1);
		chk("si_nfas", {7'h0, i[1]}, {7'h0, si});
	end
	// Drain any pending requests, then one manual E bit
	crc4_mode <= 1'b1;
	wr(4'h1, 8'h07);
	for (i = 0; i < 3; i++) tx(1'b1, 4'hd);
	for (i = 0; i < 3; i++) tx(1'b0, 4'hf);
	wr(4'h1, 8'h05);
	for (i = 0; i < 2; i++) begin
		tx(1'b1, 4'hd);
		chk("e_m13", {7'h0, i == 1}, {7'h0, si});
		tx(1'b0, 4'hf);
		chk("e_m15", 8'h01, {7'h0, si});
	end
	for (i = 0; i < 4; i++) begin
		wr(4'h1, {5'h0, i[1:0], 1'b0});
		tx(1'b1, 4'hd);
		chk("e_13", {7'h0, i[0]}, {7'h0, si});
		tx(1'b0, 4'hf);
		chk("e_15", {7'h0, i[1]}, {7'h0, si});
		tx(1'b0, 4'h5);
		chk("e_oth", 8'h01, {7'h0, si});
	end
	// E bits under receive CRC-4 multiframe loss, random enables
	for (i = 0; i < 8; i++) begin
		d = {2'b00, 2'($urandom), 4'h6};
		wr(4'h1, d);
		mfl <= 1'($urandom);
		tmr <= 1'($urandom);
		idle(3);
		tx(1'b1, 4'hd);
		chk("e_loss", {7'h0, e_exp(d, mfl, tmr)}, {7'h0, si});
	end
	mfl <= 1'b0;
	wr(4'h1, 8'h0e);
	smf_err <= 1'b1;
	@(posedge clk_sys);
	smf_err <= 1'b0;
	tx(1'b1, 4'hd);
	chk("e_auto", 8'h00, {7'h0, si});
	tx(1'b0, 4'hf);
	chk("e_once", 8'h01, {7'h0, si});
	// A bit per enabled condition
	for (i = 0; i < 6; i++) begin
		wr(4'h0, 8'h01 << i);
		cond(6'h01 << i);
		chk("a_on", 8'h01, {7'h0, a_bit});
		if (i == 0) chk("crc_f", 8'h02, {6'h0, crc_l, mon});
		cond(6'h00);
		chk("a_off", {7'h0, i == 1}, {7'h0, a_bit});
	end
	wr(4'h0, 8'h80);
	idle(3);
	chk("a_man", 8'h01, {7'h0, a_bit});
	wr(4'h0, 8'h00);
	cond(6'h3f);
	chk("a_mask", 8'h00, {7'h0, a_bit});
	cond(6'h00);
	// Sa sources: register, data links, stack, system highway
	d = 8'($urandom) & 8'h1f;
	wr(4'h3, 8'h1f);
	wr(4'h2, d);
	tx(1'b0, 4'h1);
	chk("sa_reg", d, {3'h0, sa});
	for (i = 0; i < 4; i++) begin
		wr(4'h4, {1'b0, i[0], 6'h00});
		wr(4'h2, 8'h80);
		ext_dl <= i[1];
		int_dl <= ~i[1];
		tx(1'b0, 4'h3);
		chk("sa_dl", {3'h0, {5{i[0] ~^ i[1]}}}, {3'h0, sa});
	end
	stack_sa <= 5'($urandom);
	wr(4'h2, 8'h60);
	tx(1'b0, 4'h5);
	chk("sa_stk", {3'h0, stack_sa}, {3'h0, sa});
	sa_val <= 5'($urandom);
	wr(4'h2, 8'h20);
	sys(6);
	tx(1'b0, 4'h7);
	chk("sa_sys", {3'h0, sa_val}, {3'h0, sa});
	rdc(4'h7, 8'h22);
	rdc(4'h7, 8'h02);
	bad_mark <= 1'b1;
	sys(4);
	rdc(4'h7, 8'h12);
	bad_mark <= 1'b0;
	sys(4);
	rdc(4'h7, 8'h22);
	summarize;
end
endmodule // tb_top
